// *** bench/tb_call_clear_complement_exec.sv ***
// self-checking bench for the call/clear/complement executor
`timescale 1ns/1ps
module tb_call_clear_complement_exec;
  import cce_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid = 1'b0;
  instr_t instr = '0;
  logic timeoutSet = 1'b0;
  logic powerdownSet = 1'b0;
  logic [ADDR_W-1:0] peekAddr = '0;
  logic ready, watchdogClear, zeroFlag, timeoutFlag, powerdownFlag;
  logic [PC_W-1:0] pc;
  push_t stackPush;
  logic [DATA_W-1:0] peekData;
  int fails = 0;
  int checked = 0;
  // bench model: four test bytes, pairing state, flags
  logic [DATA_W-1:0] mem [4];
  logic [ADDR_W-1:0] addrs [4] = '{8'h00, 8'hFF, 8'h3C, 8'hA5};
  pend_t pend = PEND_NONE;
  logic zExp = ZERO_FLAG_RESET;
  logic toExp = TIMEOUT_FLAG_RESET;
  logic pdExp = POWERDOWN_FLAG_RESET;

  always #4 clock = ~clock;

  call_clear_complement_exec u_dut (.clock(clock), .reset_n(reset_n),
    .instrValid(instrValid), .instr(instr), .timeoutSet(timeoutSet),
    .powerdownSet(powerdownSet), .peekAddr(peekAddr), .ready(ready),
    .pc(pc), .stackPush(stackPush), .watchdogClear(watchdogClear),
    .zeroFlag(zeroFlag), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .peekData(peekData));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one-cycle set events, kept apart from clears so no tie arises
  task automatic raise(input logic t, input logic p);
    @(posedge clock);
    timeoutSet <= t;
    powerdownSet <= p;
    @(posedge clock);
    timeoutSet <= 1'b0;
    powerdownSet <= 1'b0;
    #1;
    toExp = toExp | t;
    pdExp = pdExp | p;
    chk("timeoutFlag", toExp, timeoutFlag);
    chk("powerdownFlag", pdExp, powerdownFlag);
  endtask

  // issue one instruction, predict, then compare every result
  task automatic run(input op_t o, input int k, input logic [BIT_W-1:0] b,
                     input logic [PC_W-1:0] t);
    logic [PC_W-1:0] nx;
    push_t pushSeen;
    logic clrSeen;
    logic hit;
    int waits;
    nx = pc + PC_STEP;
    @(posedge clock);
    instrValid <= 1'b1;
    instr <= '{o, addrs[k], b, t};
    @(posedge clock);
    instrValid <= 1'b0;
    #1;
    pushSeen = stackPush;
    clrSeen = watchdogClear;
    waits = 0;
    while (ready !== 1'b1 && waits < 4) begin
      @(posedge clock);
      #1;
      waits++;
    end
    hit = 1'b0;
    case (o)
      OP_ZERO: mem[k] = BYTE_ZERO;
      OP_BIT_ZERO: mem[k][b] = 1'b0;
      OP_INVERT: begin
        mem[k] = ~mem[k];
        zExp = (mem[k] == BYTE_ZERO);
      end
      OP_WDT_CLEAR: hit = 1'b1;
      OP_PRECLEAR1: begin
        hit = (pend == PEND_SECOND);
        pend = hit ? PEND_NONE : PEND_FIRST;
      end
      OP_PRECLEAR2: begin
        hit = (pend == PEND_FIRST);
        pend = hit ? PEND_NONE : PEND_SECOND;
      end
      default: ;
    endcase
    if (hit) begin
      toExp = 1'b0;
      pdExp = 1'b0;
    end
    chk("extra cycles", 16'(o inside {OP_CALL, OP_BIT_ZERO, OP_INVERT}),
        16'(waits));
    chk("push valid", o == OP_CALL, pushSeen.valid);
    if (o == OP_CALL) begin
      chk("retAddr", nx, pushSeen.retAddr);
      chk("pc", t, pc);
    end else begin
      chk("pc", nx, pc);
    end
    chk("watchdogClear", hit, clrSeen);
    chk("timeoutFlag", toExp, timeoutFlag);
    chk("powerdownFlag", pdExp, powerdownFlag);
    chk("zeroFlag", zExp, zeroFlag);
    // peek only while idle, the read port is shared with rmw
    @(posedge clock);
    peekAddr <= addrs[k];
    repeat (2) @(posedge clock);
    #1;
    chk("memory", mem[k], peekData);
  endtask

  // main sequence: reset, corner cases, then random traffic
  initial begin
    int k;
    void'($urandom(32'hEB95));
    repeat (6) @(posedge clock);
    #1;
    chk("pc", PC_RESET, pc);
    chk("reset outputs", {3'h0, ZERO_FLAG_RESET, TIMEOUT_FLAG_RESET,
        POWERDOWN_FLAG_RESET}, {ready, stackPush.valid, watchdogClear,
        zeroFlag, timeoutFlag, powerdownFlag});
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (k = 0; k < 4; k++) run(OP_ZERO, k, 3'h0, 11'h000);
    run(OP_INVERT, 1, 3'h0, 11'h000);
    run(OP_BIT_ZERO, 1, 3'h7, 11'h000);
    run(OP_INVERT, 0, 3'h0, 11'h000);
    run(OP_INVERT, 0, 3'h0, 11'h000);
    run(OP_CALL, 2, 3'h0, 11'h7FF);
    run(OP_OTHER, 2, 3'h0, 11'h000); // pc wraps past the top
    raise(1'b1, 1'b1);
    run(OP_WDT_CLEAR, 0, 3'h0, 11'h000);
    raise(1'b1, 1'b1);
    for (k = 0; k < 3; k++) run(OP_PRECLEAR1, 0, 3'h0, 11'h000);
    run(OP_PRECLEAR2, 0, 3'h0, 11'h000);
    raise(1'b1, 1'b0);
    for (k = 0; k < 2; k++) run(OP_PRECLEAR2, 0, 3'h0, 11'h000);
    run(OP_PRECLEAR1, 0, 3'h0, 11'h000);
    for (k = 0; k < 150; k++) begin
      if ($urandom_range(3) == 0)
        raise(1'($urandom_range(1)), 1'($urandom_range(1)));
      run(op_t'($urandom_range(7)), $urandom_range(3),
          BIT_W'($urandom_range(7)), PC_W'($urandom));
    end
    test_done();
  end

  // hang guard, far above the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule

// *** hw/call_clear_complement_exec.sv ***
// executor for call, clear, bit clear, complement and watchdog clears
`timescale 1ns/1ps
module call_clear_complement_exec
  import cce_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire instr_t instr,
  input wire logic timeoutSet,
  input wire logic powerdownSet,
  input wire logic [ADDR_W-1:0] peekAddr,
  output logic ready,
  output logic [PC_W-1:0] pc,
  output push_t stackPush,
  output logic watchdogClear,
  output logic zeroFlag,
  output logic timeoutFlag,
  output logic powerdownFlag,
  output logic [DATA_W-1:0] peekData
);

  function automatic logic [PC_W-1:0] nextPc(input logic [PC_W-1:0] p);
    nextPc = p + PC_STEP;
  endfunction

  function automatic logic [DATA_W-1:0] bitMask(input logic [BIT_W-1:0] b);
    bitMask = DATA_W'(1) << b;
  endfunction

  state_t state_reg, state_next;
  pend_t pend_reg, pend_next;
  instr_t held_reg;
  logic [PC_W-1:0] pc_reg, pc_next;
  push_t push_reg, push_next;
  logic ready_reg;
  logic wdClr_reg, wdClr_next;
  logic zero_reg, zero_next;
  logic timeout_reg, timeout_next;
  logic powerdown_reg, powerdown_next;
  logic [DATA_W-1:0] ramData;

  // decode of the accepted instruction
  wire logic accept = instrValid && ready_reg && (state_reg == ST_IDLE);
  wire logic isCall = accept && (instr.op == OP_CALL);
  wire logic isZero = accept && (instr.op == OP_ZERO);
  wire logic isRmw = accept &&
    ((instr.op == OP_BIT_ZERO) || (instr.op == OP_INVERT));
  wire logic isWdt = accept && (instr.op == OP_WDT_CLEAR);
  wire logic isPre1 = accept && (instr.op == OP_PRECLEAR1);
  wire logic isPre2 = accept && (instr.op == OP_PRECLEAR2);
  wire logic inRmw = (state_reg == ST_RMW);
  wire logic rmwInvert = inRmw && (held_reg.op == OP_INVERT);

  // preclear pairs complete only on an alternation
  wire logic pairDone = (isPre1 && pend_reg == PEND_SECOND) ||
    (isPre2 && pend_reg == PEND_FIRST);
  wire logic clearWd = isWdt || pairDone;

  // read-modify-write data path
  wire logic [DATA_W-1:0] invData = ~ramData;
  wire logic [DATA_W-1:0] bitData =
    ramData & ~bitMask(held_reg.bitSel);
  wire logic [DATA_W-1:0] rmwData = rmwInvert ? invData : bitData;

  // memory ports: byte clear writes at once, rmw writes next cycle
  wire logic memWe = isZero || inRmw;
  wire logic [ADDR_W-1:0] memWa = inRmw ? held_reg.memAddr : instr.memAddr;
  wire logic [DATA_W-1:0] memWd = inRmw ? rmwData : BYTE_ZERO;
  wire logic [ADDR_W-1:0] memRa = isRmw ? instr.memAddr : peekAddr;

  data_ram ram (
    .clock(clock),
    .writeEn(memWe),
    .writeAddr(memWa),
    .writeData(memWd),
    .readAddr(memRa),
    .readData(ramData)
  );

  // sequencing: call and rmw each need a second cycle
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    push_next = '{valid: 1'b0, retAddr: push_reg.retAddr};
    unique case (state_reg)
      ST_IDLE: begin
        if (isCall) begin
          push_next = '{valid: 1'b1, retAddr: nextPc(pc_reg)};
          state_next = ST_CALL2;
        end else if (isRmw) begin
          state_next = ST_RMW;
        end else if (accept) begin
          pc_next = nextPc(pc_reg);
        end
      end
      ST_CALL2: begin
        pc_next = held_reg.target;
        state_next = ST_IDLE;
      end
      ST_RMW: begin
        pc_next = nextPc(pc_reg);
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // preclear tracking: a repeat keeps waiting for its partner
  always_comb begin
    pend_next = pend_reg;
    if (pairDone) begin
      pend_next = PEND_NONE;
    end else if (isPre1) begin
      pend_next = PEND_FIRST;
    end else if (isPre2) begin
      pend_next = PEND_SECOND;
    end
  end

  // flags: a set from the watchdog or sleep logic beats a clear
  assign wdClr_next = clearWd;
  assign timeout_next = timeoutSet || (timeout_reg && !clearWd);
  assign powerdown_next = powerdownSet || (powerdown_reg && !clearWd);
  assign zero_next = rmwInvert ? (invData == BYTE_ZERO)
    : zero_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      pend_reg <= PEND_NONE;
      pc_reg <= PC_RESET;
      push_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      pc_reg <= pc_next;
      push_reg <= push_next;
      ready_reg <= (state_next == ST_IDLE);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wdClr_reg <= 1'b0;
      zero_reg <= ZERO_FLAG_RESET;
      timeout_reg <= TIMEOUT_FLAG_RESET;
      powerdown_reg <= POWERDOWN_FLAG_RESET;
    end else begin
      wdClr_reg <= wdClr_next;
      zero_reg <= zero_next;
      timeout_reg <= timeout_next;
      powerdown_reg <= powerdown_next;
    end
  end

  // instruction held for the second cycle; no reset needed on data
  always_ff @(posedge clock) begin
    if (accept) begin
      held_reg <= instr;
    end
  end

  assign ready = ready_reg;
  assign pc = pc_reg;
  assign stackPush = push_reg;
  assign watchdogClear = wdClr_reg;
  assign zeroFlag = zero_reg;
  assign timeoutFlag = timeout_reg;
  assign powerdownFlag = powerdown_reg;
  assign peekData = ramData;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_call_push: assert property (
    isCall |=> stackPush.valid && stackPush.retAddr == nextPc($past(pc)))
    else $error("call pushed wrong return address");

  a_call_jump: assert property (
    isCall |=> ##1 pc == $past(instr.target, 2))
    else $error("call did not load target");

  a_call_cycles: assert property (
    isCall |=> !ready ##1 ready)
    else $error("call did not take two cycles");

  a_call_flags: assert property (
    isCall |=> ##1 $stable(zeroFlag))
    else $error("call changed zero flag");

  a_byte_zero: assert property (
    isZero |-> memWe && memWd == BYTE_ZERO && memWa == instr.memAddr
      ##1 $stable(zeroFlag))
    else $error("byte clear wrong");

  a_bit_only: assert property (
    inRmw && held_reg.op == OP_BIT_ZERO |-> memWd[held_reg.bitSel] == 1'b0
      && (memWd | bitMask(held_reg.bitSel))
      == (ramData | bitMask(held_reg.bitSel)))
    else $error("bit clear touched other bits");

  a_invert_zero: assert property (
    isRmw && instr.op == OP_INVERT |=> memWd == ~ramData
      ##1 zeroFlag == ($past(ramData) == BYTE_ONES))
    else $error("complement or zero flag wrong");

  a_wdt_clear: assert property (
    isWdt && !timeoutSet && !powerdownSet |=>
      watchdogClear && !timeoutFlag && !powerdownFlag)
    else $error("watchdog clear missed");

  a_pre_repeat: assert property (
    isPre1 && pend_reg != PEND_SECOND && !isWdt |=> !watchdogClear)
    else $error("lone first preclear took effect");

  // helper for the pair checks: which preclear kind waits for a partner;
  // kept apart from pend_reg so a broken pairing path still shows up
  logic armFirst_reg;
  logic armSecond_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armFirst_reg <= 1'b0;
      armSecond_reg <= 1'b0;
    end else if (isPre1) begin
      armFirst_reg <= !armSecond_reg;
      armSecond_reg <= 1'b0;
    end else if (isPre2) begin
      armSecond_reg <= !armFirst_reg;
      armFirst_reg <= 1'b0;
    end
  end

  a_pre_pair: assert property (
    isPre2 && armFirst_reg |=> watchdogClear)
    else $error("preclear pair did not clear");

  a_pair_reverse: assert property (
    isPre1 && armSecond_reg |=> watchdogClear)
    else $error("reversed preclear pair did not clear");

  a_pre2_repeat: assert property (
    isPre2 && !armFirst_reg |=> !watchdogClear)
    else $error("lone second preclear took effect");

endmodule

// *** hw/cce_pkg.sv ***
// constants, types and states for the call/clear/complement executor
package cce_pkg;

  localparam int PC_W = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BIT_W = 3;
  localparam int MEM_DEPTH = 256;

  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
  localparam logic ZERO_FLAG_RESET = 1'b0;
  localparam logic TIMEOUT_FLAG_RESET = 1'b0;
  localparam logic POWERDOWN_FLAG_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_CALL = 3'b001,
    OP_ZERO = 3'b010,
    OP_BIT_ZERO = 3'b011,
    OP_INVERT = 3'b100,
    OP_WDT_CLEAR = 3'b101,
    OP_PRECLEAR1 = 3'b110,
    OP_PRECLEAR2 = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL2 = 2'b01,
    ST_RMW = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_FIRST = 2'b01,
    PEND_SECOND = 2'b10
  } pend_t;

  // one decoded instruction from fetch/decode
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] memAddr;
    logic [BIT_W-1:0] bitSel;
    logic [PC_W-1:0] target;
  } instr_t;

  // stack push request
  typedef struct packed {
    logic valid;
    logic [PC_W-1:0] retAddr;
  } push_t;

endpackage

// *** hw/data_ram.sv ***
// data memory: one write port, one registered read port
`timescale 1ns/1ps
module data_ram
  import cce_pkg::*;
(
  input wire logic clock,
  input wire logic writeEn,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic [ADDR_W-1:0] readAddr,
  output logic [DATA_W-1:0] readData
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // read returns the old byte on a same-address write
  always_ff @(posedge clock) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end

endmodule
